// ---- rtl/event_flag_map.svh ----
// register offsets, field positions and reset values of the event flag handler
`ifndef EVENT_FLAG_MAP_SVH
`define EVENT_FLAG_MAP_SVH

`define EVT_OFF_FLAGS 4'h0
`define EVT_OFF_ENABLES 4'h1
`define EVT_OFF_TOP_CODE 4'h2
`define EVT_OFF_LEVEL_SUMMARY 4'h3
`define EVT_OFF_IRQ_MASK 4'h4
`define EVT_RST_FLAGS 8'h00
`define EVT_RST_ENABLES 8'h00
`define EVT_RST_IRQ_MASK 8'h00
`define EVT_NO_FLAG_CODE 8'hff
`define EVT_SUM_LOW_BIT 0
`define EVT_SUM_HIGH_BIT 1
`define EVT_HIGH_FIRST 4

`endif

// ---- rtl/event_flag_pkg.sv ----
// types shared by the event flag handler files
package event_flag_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] reg_addr_t;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } access_e;
endpackage

// ---- rtl/event_edge_latch.sv ----
// one event flag: input synchroniser, rising edge detector and sticky flag
`timescale 1ns/100ps
`default_nettype none
module event_edge_latch (
    input wire logic clk,
    input wire logic rst,
    input wire logic source_pin,
    input wire logic enable,
    input wire logic clear,
    output logic flag
);
    logic sync1_reg; // first stage, read only by sync2
    logic sync2_reg; // second stage
    logic prev_reg; // last sampled level for edge detect
    logic rise; // rising edge seen this cycle

    // two flops before any logic looks at the pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= source_pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // edge only counts while enabled
    assign rise = enable & sync2_reg & ~prev_reg;

    // sticky flag, set beats clear so no event is lost
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (rise) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule // event_edge_latch
`default_nettype wire

// ---- rtl/event_flag_handler.sv ----
// event flag handler: eight latched event sources in two priority levels
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "event_flag_map.svh"
module event_flag_handler #(
    parameter int NUM_SOURCES = 8, // fixed by the register layout
    parameter int HIGH_FIRST = `EVT_HIGH_FIRST // lowest source number of the high level
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] event_source,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic cpu_event_input_a,
    output logic cpu_event_input_b,
    output logic irq
);
    // the registers are one byte wide, so only eight sources fit
    initial begin
        if (NUM_SOURCES != 8 || HIGH_FIRST < 1 || HIGH_FIRST > 7) begin
            $error("event_flag_handler: unsupported NUM_SOURCES or HIGH_FIRST");
        end
    end

    event_flag_pkg::byte_t event_flags; // latched flags, one per source
    event_flag_pkg::byte_t event_enables_reg; // per-source latch enables
    event_flag_pkg::byte_t irq_mask_reg; // per-flag interrupt mask
    event_flag_pkg::byte_t top_event_code; // highest set flag number
    event_flag_pkg::byte_t event_level_summary; // level summary bits
    event_flag_pkg::byte_t clear_bits; // one-cycle clear per flag
    event_flag_pkg::byte_t rdata_next; // read mux output
    event_flag_pkg::access_e access; // decoded bus access
    logic high_level_pending; // any high flag
    logic low_level_pending; // any low flag
    logic flags_sel; // address hits flag register

    // decode the strobe pair; master never raises both
    always_comb begin
        if (reg_write) begin
            access = event_flag_pkg::ACC_WRITE;
        end else if (reg_read) begin
            access = event_flag_pkg::ACC_READ;
        end else begin
            access = event_flag_pkg::ACC_IDLE;
        end
    end

    assign flags_sel = (reg_addr == `EVT_OFF_FLAGS);

    // write one clears, zero leaves the flag alone
    assign clear_bits = (access == event_flag_pkg::ACC_WRITE && flags_sel) ? reg_wdata : 8'h00;

    // one latch per source, flag bit n fed by source n
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi = gi + 1) begin : g_src
            event_edge_latch u_latch (
                .clk(clk),
                .rst(rst),
                .source_pin(event_source[gi]),
                .enable(event_enables_reg[gi]),
                .clear(clear_bits[gi]),
                .flag(event_flags[gi])
            );
        end
    endgenerate

    // enable register, plain read-write
    always_ff @(posedge clk) begin
        if (rst) begin
            event_enables_reg <= `EVT_RST_ENABLES;
        end else if (access == event_flag_pkg::ACC_WRITE && reg_addr == `EVT_OFF_ENABLES) begin
            event_enables_reg <= reg_wdata;
        end
    end

    // interrupt mask register, same layout as the flags
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_reg <= `EVT_RST_IRQ_MASK;
        end else if (access == event_flag_pkg::ACC_WRITE && reg_addr == `EVT_OFF_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata;
        end
    end

    // level summary from the latched flags, never the raw pins
    assign high_level_pending = |event_flags[7:HIGH_FIRST];
    assign low_level_pending = |event_flags[HIGH_FIRST-1:0];

    // upper summary bits always zero
    always_comb begin
        event_level_summary = 8'h00;
        event_level_summary[`EVT_SUM_HIGH_BIT] = high_level_pending;
        event_level_summary[`EVT_SUM_LOW_BIT] = low_level_pending;
    end

    // priority encoder: scan upward so the highest set flag wins
    always_comb begin
        top_event_code = `EVT_NO_FLAG_CODE;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            if (event_flags[i]) begin
                top_event_code = 8'(i);
            end
        end
    end

    // cpu requests follow the latched flags, so they hold until cleared
    assign cpu_event_input_a = high_level_pending;
    assign cpu_event_input_b = low_level_pending;

    // one level interrupt while any unmasked flag stands
    assign irq = |(event_flags & irq_mask_reg);

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (reg_addr)
            `EVT_OFF_FLAGS: rdata_next = event_flags;
            `EVT_OFF_ENABLES: rdata_next = event_enables_reg;
            `EVT_OFF_TOP_CODE: rdata_next = top_event_code;
            `EVT_OFF_LEVEL_SUMMARY: rdata_next = event_level_summary;
            `EVT_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // read data registered, valid only the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (access == event_flag_pkg::ACC_READ) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // event_flag_handler
`default_nettype wire

// ---- test/event_source_model.sv ----
// peripheral event source model feeding the event pins
`timescale 1ns/100ps
`default_nettype none
module event_source_model (
    input wire logic clk,
    input wire logic [7:0] fire,
    output logic [7:0] src
);
    logic [7:0] d1; // stretch stage one
    logic [7:0] d2; // stretch stage two
    // three-cycle pulse, then low again so the next request gives a fresh edge
    always_ff @(posedge clk) begin
        d1 <= fire;
        d2 <= d1;
        src <= fire | d1 | d2;
    end
endmodule // event_source_model
`default_nettype wire

// ---- test/event_flag_monitor.sv ----
// port-level checks of the event flag handler
`timescale 1ns/100ps
`default_nettype none
module event_flag_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] event_source,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic cpu_event_input_a,
    input wire logic cpu_event_input_b,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire clr = reg_write && reg_addr == 4'h0; // flag register write
    reset_clears_a: assert property ($fell(rst) |-> !cpu_event_input_a && !cpu_event_input_b && !irq)
        else $error("request alive after reset");
    low_cause_a: assert property ($rose(cpu_event_input_b) |-> $past(|event_source[3:0], 3))
        else $error("low request without source edge");
    high_cause_a: assert property ($rose(cpu_event_input_a) |-> $past(|event_source[7:4], 3))
        else $error("high request without source edge");
    low_hold_a: assert property (cpu_event_input_b && !(clr && |reg_wdata[3:0]) |=> cpu_event_input_b)
        else $error("low request dropped");
    high_hold_a: assert property (cpu_event_input_a && !(clr && |reg_wdata[7:4]) |=> cpu_event_input_a)
        else $error("high request dropped");
    clear_all_a: assert property (clr && reg_wdata == 8'hff && $past(event_source, 2) == 8'h00
        |=> !cpu_event_input_a && !cpu_event_input_b) else $error("flags survive clear");
    idle_code_a: assert property (reg_read && reg_addr == 4'h2 && !cpu_event_input_a && !cpu_event_input_b
        |=> reg_rdata == 8'hff) else $error("code not all ones");
    high_code_a: assert property (reg_read && reg_addr == 4'h2 && cpu_event_input_a
        |=> reg_rdata[7:2] == 6'h01) else $error("code not a high source");
    level_summary_a: assert property (reg_read && reg_addr == 4'h3
        |=> reg_rdata == {6'h00, $past(cpu_event_input_a), $past(cpu_event_input_b)}) else $error("bad summary");
    irq_cause_a: assert property (irq |-> cpu_event_input_a || cpu_event_input_b)
        else $error("irq without flag");
endmodule // event_flag_monitor
bind event_flag_handler event_flag_monitor u_mon (.clk, .rst, .event_source, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .cpu_event_input_a, .cpu_event_input_b, .irq);
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the event flag handler
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, rd_q = 0, irq, cpu_a, cpu_b;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, fire = 8'h00, src, reg_rdata, en, exp_f;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int failures = 0, n_checks = 0, cycles = 0, seed = 25;
    event_source_model u_src (.clk(clk), .fire(fire), .src(src));
    event_flag_handler u_dut (.clk(clk), .rst(rst), .event_source(src), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cpu_event_input_a(cpu_a),
        .cpu_event_input_b(cpu_b), .irq(irq));
    initial forever #5 clk = ~clk;
    task cmp(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want) begin
            failures++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one bus cycle; for a read the data argument is the expected answer
    task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) exp_q.push_back(d);
        @(posedge clk);
    endtask
    function automatic logic [7:0] top(input logic [7:0] f);
        top = 8'hff;
        for (int i = 0; i < 8; i++) begin
            if (f[i]) top = 8'(i);
        end
    endfunction
    // watcher: read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        cycles++;
        rd_q <= reg_read;
        if (rd_q) cmp(reg_rdata, exp_q.pop_front());
        if (cycles > 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        bus(0, 1, 4'h0, 8'h00);
        bus(0, 1, 4'h1, 8'h00);
        bus(1, 0, 4'h2, 8'h12);
        bus(0, 1, 4'h2, 8'hff);
        bus(0, 1, 4'h3, 8'h00);
        bus(0, 1, 4'h7, 8'h00);
        // random sources against random enables; disabled edges are lost
        repeat (8) begin
            en = 8'($random(seed));
            exp_f = 8'($random(seed));
            fire <= exp_f;
            bus(1, 0, 4'h1, en);
            fire <= 8'h00;
            bus(1, 0, 4'h4, en ^ 8'h0f);
            repeat (3) bus(0, 0, 4'h0, 8'h00);
            bus(0, 1, 4'h0, exp_f & en);
            bus(0, 1, 4'h2, top(exp_f & en));
            bus(0, 1, 4'h3, {6'h00, |(exp_f[7:4] & en[7:4]), |(exp_f[3:0] & en[3:0])});
            bus(0, 1, 4'h4, en ^ 8'h0f);
            bus(0, 1, 4'h1, en);
            cmp({7'h00, irq}, {7'h00, |(exp_f & en & (en ^ 8'h0f))});
            cmp({6'h00, cpu_a, cpu_b}, {6'h00, |(exp_f[7:4] & en[7:4]), |(exp_f[3:0] & en[3:0])});
            bus(1, 0, 4'h0, 8'hff);
        end
        // clear lands on the edge that sets the flag: the event must survive
        bus(1, 0, 4'h1, 8'h01);
        fire <= 8'h01;
        bus(0, 0, 4'h0, 8'h00);
        fire <= 8'h00;
        repeat (2) bus(0, 0, 4'h0, 8'h00);
        bus(1, 0, 4'h0, 8'h01);
        bus(0, 1, 4'h0, 8'h01);
        bus(1, 0, 4'h0, 8'hff);
        bus(0, 1, 4'h0, 8'h00);
        // latch a new event, then reset in mid-run: everything must drop
        fire <= 8'h01;
        repeat (5) bus(0, 0, 4'h0, 8'h00);
        fire <= 8'h00;
        cmp({6'h00, cpu_a, cpu_b}, 8'h01);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        bus(0, 1, 4'h0, 8'h00);
        bus(0, 1, 4'h1, 8'h00);
        bus(0, 1, 4'h2, 8'hff);
        repeat (2) bus(0, 0, 4'h0, 8'h00);
        cmp({6'h00, cpu_a, cpu_b}, 8'h00);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
